// [common/rdc_pkg.sv]
// shared constants and types for the rs485 direction control block
package rdc_pkg;
  // operating modes decoded from the selector switches
  typedef enum logic [2:0] {
    RDC_MODE_INVALID = 3'b000,
    RDC_MODE_MASTER = 3'b001,
    RDC_MODE_ECHO_HS = 3'b010,
    RDC_MODE_NOECHO_HS = 3'b011,
    RDC_MODE_ECHO_AUTO = 3'b100,
    RDC_MODE_NOECHO_AUTO = 3'b101
  } rdc_mode_type;

  // switch pattern {bit8,bit5,bit4,bit3,bit2,bit1}
  localparam logic [5:0] RDC_SW_MASTER = 6'h08;
  localparam logic [5:0] RDC_SW_ECHO_HS = 6'h0C;
  localparam logic [5:0] RDC_SW_NOECHO_HS = 6'h0D;
  localparam logic [5:0] RDC_SW_ECHO_AUTO = 6'h0A;
  localparam logic [5:0] RDC_SW_NOECHO_AUTO = 6'h0B;

  // clock and switchover timing
  localparam int RDC_CLK_HZ = 125000000;
  localparam int RDC_SWITCH_DELAY_NS = 10000;
  localparam int RDC_SWITCH_CYCLES =
    RDC_SWITCH_DELAY_NS / (1000000000 / RDC_CLK_HZ);
  localparam int RDC_CNT_W = 12;

  // reset values
  localparam logic RDC_RST_DRIVER_EN = 1'b0;
  localparam logic RDC_RST_RX_EN = 1'b1;
  localparam logic RDC_RST_SYNC = 1'b1;
endpackage

// [verilog/rdc_sync.sv]
// two flip-flop level synchroniser for pin inputs
`timescale 1ns/1ns
module rdc_sync #(
  parameter logic RST_VAL = 1'b1
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic arst_n,
  // level in and out
  input wire logic din,
  output logic dout
);
  logic meta;

  // first stage is read only by the second stage
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      meta <= RST_VAL;
      dout <= RST_VAL;
    end else begin
      meta <= din;
      dout <= meta;
    end
  end
endmodule

// [verilog/rdc_top.sv]
// direction and receive gating control for an rs485 line interface
// How it works
// - mode decoded from six selector switch bits
// - five modes, chosen only by static switches
// - bus master keeps driver and receiver enabled
// - handshake modes drive while handshake input high
// - automatic modes drive when transmit data starts
// - echo modes keep receiver always enabled
// - no-echo modes block receiver while driving
// - automatic release about 10 us after idle
`timescale 1ns/1ns
module rdc_top
  import rdc_pkg::*;
#(
  parameter int SWITCH_CYCLES = rdc_pkg::RDC_SWITCH_CYCLES
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic arst_n,
  // mode selector switches
  input wire logic mode_selector_bit_1,
  input wire logic mode_selector_bit_2,
  input wire logic mode_selector_bit_3,
  input wire logic mode_selector_bit_4,
  input wire logic mode_selector_bit_5,
  input wire logic mode_selector_bit_8,
  // host side pins
  input wire logic tx_data_in,
  input wire logic handshake_in,
  // line side controls
  output logic tx_data_out,
  output logic driver_en,
  output logic rx_en,
  output logic handshake_driver_en,
  // status
  output logic mode_valid,
  output logic [2:0] mode
);
  import rdc_pkg::*;

  logic tx_sync;
  logic hs_sync;
  logic [5:0] sw_meta;
  logic [5:0] sw_sync;
  rdc_mode_type cur_mode;
  rdc_mode_type next_mode;
  logic [RDC_CNT_W-1:0] idle_cnt;
  logic auto_drive;
  logic next_drive;

  localparam logic [RDC_CNT_W-1:0] IDLE_MAX =
    RDC_CNT_W'(SWITCH_CYCLES);

  // switch pattern to mode; applied only to the synchronised switches
  function automatic rdc_mode_type rdc_decode(input logic [5:0] sw);
    case (sw)
      RDC_SW_MASTER: rdc_decode = RDC_MODE_MASTER;
      RDC_SW_ECHO_HS: rdc_decode = RDC_MODE_ECHO_HS;
      RDC_SW_NOECHO_HS: rdc_decode = RDC_MODE_NOECHO_HS;
      RDC_SW_ECHO_AUTO: rdc_decode = RDC_MODE_ECHO_AUTO;
      RDC_SW_NOECHO_AUTO: rdc_decode = RDC_MODE_NOECHO_AUTO;
      default: rdc_decode = RDC_MODE_INVALID;
    endcase
  endfunction

  // pin inputs through two flip-flops before use
  rdc_sync #(.RST_VAL(RDC_RST_SYNC)) u_tx_sync (
    .sys_clk(sys_clk),
    .arst_n(arst_n),
    .din(tx_data_in),
    .dout(tx_sync)
  );
  rdc_sync #(.RST_VAL(1'b0)) u_hs_sync (
    .sys_clk(sys_clk),
    .arst_n(arst_n),
    .din(handshake_in),
    .dout(hs_sync)
  );

  // switches are static but still cross in through two stages
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      sw_meta <= 6'h00;
      sw_sync <= 6'h00;
    end else begin
      sw_meta <= {mode_selector_bit_8, mode_selector_bit_5,
                  mode_selector_bit_4, mode_selector_bit_3,
                  mode_selector_bit_2, mode_selector_bit_1};
      sw_sync <= sw_meta;
    end
  end

  // decode the mode; unknown patterns fall back to a safe listen state
  always_comb begin
    next_mode = rdc_decode(sw_sync);
  end

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      cur_mode <= RDC_MODE_INVALID;
    end else begin
      cur_mode <= next_mode;
    end
  end

  // idle-high counter; any low bit restarts the hold time
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      idle_cnt <= '0;
    end else if (!tx_sync) begin
      idle_cnt <= '0;
    end else if (idle_cnt != IDLE_MAX) begin
      idle_cnt <= idle_cnt + RDC_CNT_W'(1);
    end
  end

  // automatic driver: on at first low bit, off after the idle delay
  always_comb begin
    next_drive = auto_drive;
    if (!tx_sync) begin
      next_drive = 1'b1;
    end else if (idle_cnt == IDLE_MAX - RDC_CNT_W'(1)) begin
      next_drive = 1'b0;
    end
  end

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      auto_drive <= RDC_RST_DRIVER_EN;
    end else begin
      auto_drive <= next_drive;
    end
  end

  // line outputs registered; data is delayed to match driver enable
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      driver_en <= RDC_RST_DRIVER_EN;
      rx_en <= RDC_RST_RX_EN;
      handshake_driver_en <= 1'b0;
      tx_data_out <= RDC_RST_SYNC;
    end else begin
      tx_data_out <= tx_sync;
      case (cur_mode)
        RDC_MODE_MASTER: begin
          driver_en <= 1'b1;
          rx_en <= 1'b1;
          handshake_driver_en <= 1'b1;
        end
        RDC_MODE_ECHO_HS: begin
          driver_en <= hs_sync;
          rx_en <= 1'b1;
          handshake_driver_en <= 1'b0;
        end
        RDC_MODE_NOECHO_HS: begin
          driver_en <= hs_sync;
          rx_en <= !hs_sync;
          handshake_driver_en <= 1'b0;
        end
        RDC_MODE_ECHO_AUTO: begin
          driver_en <= next_drive;
          rx_en <= 1'b1;
          handshake_driver_en <= 1'b0;
        end
        RDC_MODE_NOECHO_AUTO: begin
          driver_en <= next_drive;
          rx_en <= !next_drive;
          handshake_driver_en <= 1'b0;
        end
        default: begin
          driver_en <= 1'b0;
          rx_en <= 1'b1;
          handshake_driver_en <= 1'b0;
        end
      endcase
    end
  end

  // status outputs
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      mode_valid <= 1'b0;
      mode <= 3'h0;
    end else begin
      mode_valid <= (cur_mode != RDC_MODE_INVALID);
      mode <= cur_mode;
    end
  end

  // assertions
  property p_master_on;
    @(posedge sys_clk) disable iff (!arst_n)
    cur_mode == RDC_MODE_MASTER |=> driver_en && rx_en;
  endproperty
  a_master_on: assert property (p_master_on)
    else $error("master mode must keep driver and receiver on");

  property p_hs_follow;
    @(posedge sys_clk) disable iff (!arst_n)
    (cur_mode == RDC_MODE_ECHO_HS || cur_mode == RDC_MODE_NOECHO_HS)
      |=> driver_en == $past(hs_sync);
  endproperty
  a_hs_follow: assert property (p_hs_follow)
    else $error("handshake mode driver does not follow handshake");

  property p_echo_rx;
    @(posedge sys_clk) disable iff (!arst_n)
    (cur_mode == RDC_MODE_ECHO_HS || cur_mode == RDC_MODE_ECHO_AUTO)
      |=> rx_en;
  endproperty
  a_echo_rx: assert property (p_echo_rx)
    else $error("echo mode receiver disabled");

  property p_noecho_excl;
    @(posedge sys_clk) disable iff (!arst_n)
    $past(cur_mode == RDC_MODE_NOECHO_HS ||
          cur_mode == RDC_MODE_NOECHO_AUTO) |-> rx_en != driver_en;
  endproperty
  a_noecho_excl: assert property (p_noecho_excl)
    else $error("no-echo receiver not opposite to driver");

  sequence s_tx_low;
    !tx_sync && cur_mode == RDC_MODE_ECHO_AUTO;
  endsequence
  property p_auto_on;
    @(posedge sys_clk) disable iff (!arst_n)
    s_tx_low ##1 cur_mode == RDC_MODE_ECHO_AUTO |-> driver_en;
  endproperty
  a_auto_on: assert property (p_auto_on)
    else $error("automatic driver not enabled on transmit start");

  property p_auto_hold;
    @(posedge sys_clk) disable iff (!arst_n)
    idle_cnt < IDLE_MAX - RDC_CNT_W'(1) && auto_drive |=> auto_drive;
  endproperty
  a_auto_hold: assert property (p_auto_hold)
    else $error("automatic driver released before the delay");

  property p_auto_release;
    @(posedge sys_clk) disable iff (!arst_n)
    idle_cnt == IDLE_MAX |-> !auto_drive;
  endproperty
  a_auto_release: assert property (p_auto_release)
    else $error("automatic driver still on after the delay");

  property p_cnt_clear;
    @(posedge sys_clk) disable iff (!arst_n)
    !tx_sync |=> idle_cnt == '0;
  endproperty
  a_cnt_clear: assert property (p_cnt_clear)
    else $error("idle counter not cleared by low transmit data");

  property p_invalid_safe;
    @(posedge sys_clk) disable iff (!arst_n)
    cur_mode == RDC_MODE_INVALID |=> !driver_en && rx_en;
  endproperty
  a_invalid_safe: assert property (p_invalid_safe)
    else $error("unknown switch pattern must leave line listening");
endmodule

// [dv/rdc_host_model.sv]
// rs232 host model: sends one frame with or without handshake
`timescale 1ns/1ns
module rdc_host_model (
  // clock and reset
  input wire logic sys_clk,
  input wire logic arst_n,
  // bench control
  input wire logic send_req,
  input wire logic use_hs,
  // host pins
  output logic tx_data,
  output logic hs_out,
  output logic busy
);
  logic [4:0] cnt;

  // frame sequencer; a bench-commanded frame runs 16 clocks with or without handshake
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      busy <= 1'b0;
      cnt <= 5'h00;
    end else if (busy) begin
      cnt <= cnt + 5'h01;
      if (cnt == 5'h0F) begin
        busy <= 1'b0;
      end
    end else if (send_req) begin
      busy <= 1'b1;
      cnt <= 5'h00;
    end
  end

  // handshake up 4 clocks before data, down 4 clocks after idle
  assign hs_out = use_hs && busy;
  // data low for 8 clocks, idle high otherwise
  assign tx_data = !(busy && cnt >= 5'h04 && cnt < 5'h0C);
endmodule

// [dv/rdc_top_test.sv]
// self-checking bench for the rs485 direction control block
`timescale 1ns/1ns
`define CHK(what, exp, got) begin \
  total_checks++; \
  if ((got) !== (exp)) begin \
    failures++; \
    $display("mismatch %s exp %h got %h", what, exp, got); \
  end \
end
module rdc_top_test;
  import rdc_pkg::*;
  typedef struct {
    logic [5:0] sw;
    rdc_mode_type md;
    logic vld, drv, rx, hsd;
  } rdc_row_type;
  logic sys_clk = 1'b0;
  logic arst_n = 1'b0;
  logic [5:0] sw = 6'h00;
  logic send_req = 1'b0;
  logic use_hs = 1'b0;
  logic tx_data_in, handshake_in, tx_data_out, driver_en, rx_en;
  logic handshake_driver_en, mode_valid;
  logic [2:0] mode;
  int failures = 0;
  int total_checks = 0;
  // idle expectations: no frame in flight, handshake low
  rdc_row_type rows [7] = '{
    '{RDC_SW_MASTER, RDC_MODE_MASTER, 1'b1, 1'b1, 1'b1, 1'b1},
    '{RDC_SW_ECHO_HS, RDC_MODE_ECHO_HS, 1'b1, 1'b0, 1'b1, 1'b0},
    '{RDC_SW_NOECHO_HS, RDC_MODE_NOECHO_HS, 1'b1, 1'b0, 1'b1, 1'b0},
    '{RDC_SW_ECHO_AUTO, RDC_MODE_ECHO_AUTO, 1'b1, 1'b0, 1'b1, 1'b0},
    '{RDC_SW_NOECHO_AUTO, RDC_MODE_NOECHO_AUTO, 1'b1, 1'b0, 1'b1, 1'b0},
    '{6'h00, RDC_MODE_INVALID, 1'b0, 1'b0, 1'b1, 1'b0},
    '{6'h2A, RDC_MODE_INVALID, 1'b0, 1'b0, 1'b1, 1'b0}};

  // clock at 125 MHz
  always #4 sys_clk = ~sys_clk;

  rdc_top #(.SWITCH_CYCLES(8)) i_rdc_top (
    .sys_clk(sys_clk), .arst_n(arst_n),
    .mode_selector_bit_1(sw[0]), .mode_selector_bit_2(sw[1]),
    .mode_selector_bit_3(sw[2]), .mode_selector_bit_4(sw[3]),
    .mode_selector_bit_5(sw[4]), .mode_selector_bit_8(sw[5]),
    .tx_data_in(tx_data_in), .handshake_in(handshake_in),
    .tx_data_out(tx_data_out), .driver_en(driver_en), .rx_en(rx_en),
    .handshake_driver_en(handshake_driver_en),
    .mode_valid(mode_valid), .mode(mode));

  rdc_host_model i_rdc_host_model (
    .sys_clk(sys_clk), .arst_n(arst_n), .send_req(send_req),
    .use_hs(use_hs), .tx_data(tx_data_in), .hs_out(handshake_in),
    .busy());

  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // one frame; switch delay is 8 so release lands 10 clocks after idle
  task automatic run_frame(input logic hs, input logic drv, input logic rx);
    int n;
    use_hs = hs;
    send_req = 1'b1;
    tick(1);
    send_req = 1'b0;
    n = 0;
    while (tx_data_in !== 1'b0 && n < 50) begin
      tick(1);
      n++;
    end
    tick(4);
    `CHK("drv_on", drv, driver_en)
    `CHK("rx_tx", rx, rx_en)
    `CHK("txd", 1'b0, tx_data_out)
    while (tx_data_in !== 1'b1 && n < 100) begin
      tick(1);
      n++;
    end
    tick(5);
    `CHK("drv_hold", drv, driver_en)
    tick(10);
    `CHK("drv_off", 1'b0, driver_en)
    `CHK("rx_back", 1'b1, rx_en)
    $display("frame test done");
  endtask

  // watchdog: all tests take well under 1000 clocks
  initial begin
    #(8 * 3000);
    failures++;
    tally_and_finish();
  end

  initial begin
    tick(3);
    arst_n = 1'b1;
    tick(1);
    // ordinary cases: the five valid switch patterns and two unknown ones, idle outputs
    foreach (rows[i]) begin
      sw = rows[i].sw;
      tick(6);
      `CHK("mode", rows[i].md, mode)
      `CHK("valid", rows[i].vld, mode_valid)
      `CHK("drv", rows[i].drv, driver_en)
      `CHK("rx", rows[i].rx, rx_en)
      `CHK("hsdrv", rows[i].hsd, handshake_driver_en)
    end
    $display("mode table test done");
    sw = RDC_SW_ECHO_HS;
    tick(6);
    run_frame(1'b1, 1'b1, 1'b1);
    sw = RDC_SW_NOECHO_HS;
    tick(6);
    run_frame(1'b1, 1'b1, 1'b0);
    // host forgets its handshake: driver must stay off
    run_frame(1'b0, 1'b0, 1'b1);
    sw = RDC_SW_ECHO_AUTO;
    tick(6);
    run_frame(1'b0, 1'b1, 1'b1);
    sw = RDC_SW_NOECHO_AUTO;
    tick(6);
    run_frame(1'b0, 1'b1, 1'b0);
    // reset in mid-run while in master mode
    sw = RDC_SW_MASTER;
    tick(6);
    arst_n = 1'b0;
    tick(2);
    `CHK("rst_drv", 1'b0, driver_en)
    `CHK("rst_rx", 1'b1, rx_en)
    `CHK("rst_mode", 3'h0, mode)
    arst_n = 1'b1;
    tick(6);
    `CHK("rst_back", 1'b1, driver_en)
    $display("reset test done");
    tally_and_finish();
  end
endmodule
